//--- matl_asserts.sv
// Port checker for the MAC address table
`timescale 1ns/10ps
`default_nettype none
`include "matl_consts.vh"
// ------------------------------
// Answer timing and aging checks
// ------------------------------
module matl_asserts (
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic       lookupValid,
    input wire logic       lookupDone,
    input wire logic       lookupHit,
    input wire logic [9:0] lookupPorts,
    input wire logic       cmdValid,
    input wire logic [2:0] cmdOp,
    input wire logic [9:0] cmdAge,
    input wire logic       cmdDone,
    input wire logic       cmdOk,
    input wire logic       rdValid,
    input wire logic [9:0] ageTime
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Aging command and its legal range
    wire ageCmd = cmdValid && cmdOp == `MATL_CMD_AGE;
    wire ageIn  = cmdAge >= `MATL_AGE_MIN && cmdAge <= `MATL_AGE_MAX;

    lookup_answer_a: assert property (lookupValid |=> lookupDone)
        else $error("lookup not answered next cycle");
    lookup_quiet_a: assert property (!lookupValid |=> !lookupDone)
        else $error("lookup answer without request");
    miss_ports_a: assert property (lookupDone && !lookupHit |->
        lookupPorts == 10'h000) else $error("ports on a miss");
    cmd_answer_a: assert property (cmdValid |=> cmdDone)
        else $error("command not answered next cycle");
    age_take_a: assert property (ageCmd && ageIn |=>
        cmdOk && ageTime == $past(cmdAge)) else $error("age not taken");
    age_refuse_a: assert property (ageCmd && !ageIn |=>
        !cmdOk && $stable(ageTime)) else $error("bad age accepted");
    age_hold_a: assert property (!ageCmd |=> $stable(ageTime))
        else $error("age changed without command");
    age_reset_a: assert property ($rose(resetn) |->
        ageTime == `MATL_AGE_DEFAULT) else $error("age after reset");
    read_flags_a: assert property (rdValid |-> cmdDone && cmdOk)
        else $error("entry shown without good read");
endmodule // matl_asserts

bind matl_table matl_asserts chk (
    .core_clk(core_clk), .resetn(resetn), .lookupValid(lookupValid),
    .lookupDone(lookupDone), .lookupHit(lookupHit),
    .lookupPorts(lookupPorts), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdAge(cmdAge), .cmdDone(cmdDone), .cmdOk(cmdOk),
    .rdValid(rdValid), .ageTime(ageTime));
`default_nettype wire

//--- matl_consts.vh
// Constants for the MAC address table with learning and aging
`ifndef MATL_CONSTS_VH
`define MATL_CONSTS_VH
// Table geometry
`define MATL_ENTRIES      8
`define MATL_IDX_W        3
`define MATL_PORTS        10
`define MATL_MAC_W        48
`define MATL_VLAN_W       12
// Aging interval in seconds
`define MATL_AGE_DEFAULT  10'h12c
`define MATL_AGE_MIN      10'h00a
`define MATL_AGE_MAX      10'h276
// Clock rate in Hz; one second of core_clk cycles
`define MATL_CLK_HZ       10000000
`define MATL_SEC_CYCLES   24'h989680
// Management command codes
`define MATL_CMD_ADD      3'h1
`define MATL_CMD_DEL      3'h2
`define MATL_CMD_PROMOTE  3'h3
`define MATL_CMD_AGE      3'h4
`define MATL_CMD_READ     3'h5
`endif

//--- matl_pipe_model.sv
// Receive and forwarding pipeline model
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Learning and lookup requests
// ------------------------------
module matl_pipe_model (
    input  wire logic        core_clk,
    output var  logic        lookupValid = 1'h0,
    output var  logic [47:0] lookupMac = 48'h0,
    output var  logic [11:0] lookupVlan = 12'h0,
    input  wire logic        lookupDone,
    input  wire logic        lookupHit,
    input  wire logic [9:0]  lookupPorts,
    output var  logic        learnValid = 1'h0,
    output var  logic [47:0] learnMac = 48'h0,
    output var  logic [11:0] learnVlan = 12'h0,
    output var  logic [9:0]  learnPort = 10'h0
);
    // One learn pulse; key lines scrambled once it is taken
    task automatic learn(input logic [47:0] m, input logic [11:0] v,
                         input logic [9:0] p);
        @(negedge core_clk);
        {learnMac, learnVlan, learnPort} = {m, v, p};
        learnValid = 1'h1;
        @(negedge core_clk);
        learnValid = 1'h0;
        {learnMac, learnVlan} = ~{m, v};
    endtask

    // One lookup pulse; answer taken one cycle later
    task automatic lookup(input logic [47:0] m, input logic [11:0] v,
                          output logic h, output logic [9:0] p,
                          output logic d);
        @(negedge core_clk);
        {lookupMac, lookupVlan} = {m, v};
        lookupValid = 1'h1;
        @(negedge core_clk);
        lookupValid = 1'h0;
        {lookupMac, lookupVlan} = ~{m, v};
        {h, p, d} = {lookupHit, lookupPorts, lookupDone};
    endtask
endmodule // matl_pipe_model
`default_nettype wire

//--- matl_second_tick.v
// One-second tick generator for the aging timer
`timescale 1ns/10ps
`default_nettype none
`include "matl_consts.vh"

module matl_second_tick #(
    parameter [23:0] SEC_CYCLES = `MATL_SEC_CYCLES
) (
    input  wire core_clk,
    input  wire resetn,
    output reg  tick
);
    reg [23:0] count;

    // Count up one second, pulse tick at wrap
    always @(posedge core_clk)
    begin
        if (!resetn)
        begin
            count <= 24'h000000;
            tick  <= 1'b0;
        end
        else if (count == SEC_CYCLES - 24'h000001)
        begin
            count <= 24'h000000;
            tick  <= 1'b1;
        end
        else
        begin
            count <= count + 24'h000001;
            tick  <= 1'b0;
        end
    end
endmodule // matl_second_tick
`default_nettype wire

//--- matl_table.v
// MAC address table: lookup, learning, aging, static entries, sorted read
// Summary of operation
// - Destination MAC and VLAN lookup returns the egress port set
// - Static and dynamic entries share one table with a type flag
// - Static entries from management are never learned over or aged
// - Source MAC of a received frame creates or refreshes a dynamic entry, except in a cycle with an add, delete or promote command
// - Dynamic entry is removed when unseen for the aging interval
// - Aging interval is 300 seconds after reset
// - Aging interval accepted only from 10 to 630 seconds, else rejected
// - Read-out returns entries ordered by VLAN then MAC
// - Reported entry carries MAC, VLAN, type flag and ports
// - Promote command turns a dynamic entry static, keeping its fields
// - Add installs a static entry; delete removes it
`timescale 1ns/10ps
`default_nettype none
`include "matl_consts.vh"

module matl_table #(
    parameter [23:0] SEC_CYCLES = `MATL_SEC_CYCLES
) (
    input  wire        core_clk,
    input  wire        resetn,
    // Lookup request from forwarding pipeline
    input  wire        lookupValid,
    input  wire [47:0] lookupMac,
    input  wire [11:0] lookupVlan,
    output reg         lookupDone,
    output reg         lookupHit,
    output reg  [9:0]  lookupPorts,
    // Learning request from receive pipeline
    input  wire        learnValid,
    input  wire [47:0] learnMac,
    input  wire [11:0] learnVlan,
    input  wire [9:0]  learnPort,
    // Management command
    input  wire        cmdValid,
    input  wire [2:0]  cmdOp,
    input  wire [47:0] cmdMac,
    input  wire [11:0] cmdVlan,
    input  wire [9:0]  cmdPorts,
    input  wire [9:0]  cmdAge,
    output reg         cmdDone,
    output reg         cmdOk,
    // Read-out entry
    output reg         rdValid,
    output reg  [47:0] rdMac,
    output reg  [11:0] rdVlan,
    output reg         rdStatic,
    output reg  [9:0]  rdPorts,
    output reg  [9:0]  ageTime
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    reg [47:0] eMac    [0:7];
    reg [11:0] eVlan   [0:7];
    reg [9:0]  ePorts  [0:7];
    reg [9:0]  eAge    [0:7];
    reg [7:0]  eValid;
    reg [7:0]  eStatic;
    reg [3:0]  i, iFlat, iFree, iRd;
    wire       secTick;

    // Sort key of an entry: VLAN then MAC
    function [59:0] keyOf;
        input [11:0] v;
        input [47:0] m;
        begin
            keyOf = {v, m};
        end
    endfunction

    // Search index of matching entry, bit 3 set when found
    function [3:0] findIdx;
        input [47:0] m;
        input [11:0] v;
        input [7:0]  vl;
        input [383:0] macs;
        input [95:0]  vlans;
        integer k;
        begin
            findIdx = 4'h0;
            for (k = 7; k >= 0; k = k - 1)
                if (vl[k] && macs[k*48 +: 48] == m && vlans[k*12 +: 12] == v)
                    findIdx = {1'b1, k[2:0]};
        end
    endfunction

    // Flattened copies for function arguments
    reg [383:0] flatMac;
    reg [95:0]  flatVlan;
    always @*
    begin
        flatMac  = 384'h0;
        flatVlan = 96'h0;
        for (iFlat = 0; iFlat < 8; iFlat = iFlat + 1)
        begin
            flatMac[iFlat*48 +: 48]  = eMac[iFlat[2:0]];
            flatVlan[iFlat*12 +: 12] = eVlan[iFlat[2:0]];
        end
    end

    // First free slot, bit 3 set when any free
    reg [3:0] freeIdx;
    always @*
    begin
        freeIdx = 4'h0;
        for (iFree = 0; iFree < 8; iFree = iFree + 1)
            if (!eValid[7 - iFree[2:0]])
                freeIdx = {1'b1, 3'h7 - iFree[2:0]};
    end

    wire [3:0] lkHit = findIdx(lookupMac, lookupVlan, eValid, flatMac, flatVlan);
    wire [3:0] lnHit = findIdx(learnMac, learnVlan, eValid, flatMac, flatVlan);
    wire [3:0] cmHit = findIdx(cmdMac, cmdVlan, eValid, flatMac, flatVlan);
    wire [2:0] addSlot = cmHit[3] ? cmHit[2:0] : freeIdx[2:0];

    // Smallest key above last reported key, for sorted read-out
    reg [59:0] lastKey;
    reg        rdFirst;
    reg [3:0]  nextRd;
    reg [59:0] bestKey;
    always @*
    begin
        nextRd  = 4'h0;
        bestKey = 60'hfffffffffffffff;
        for (iRd = 0; iRd < 8; iRd = iRd + 1)
            if (eValid[iRd[2:0]]
                && (rdFirst
                    || keyOf(eVlan[iRd[2:0]], eMac[iRd[2:0]]) > lastKey)
                && (!nextRd[3]
                    || keyOf(eVlan[iRd[2:0]], eMac[iRd[2:0]]) < bestKey))
            begin
                nextRd  = {1'b1, iRd[2:0]};
                bestKey = keyOf(eVlan[iRd[2:0]], eMac[iRd[2:0]]);
            end
    end

    // ------------------------------------------------------------
    // Second tick
    // ------------------------------------------------------------
    matl_second_tick #(
        .SEC_CYCLES (SEC_CYCLES)
    ) uTick (
        .core_clk (core_clk),
        .resetn   (resetn),
        .tick     (secTick)
    );

    // ------------------------------------------------------------
    // Lookup path
    // ------------------------------------------------------------
    // Registered lookup answer one cycle after request
    always @(posedge core_clk)
    begin
        if (!resetn)
        begin
            lookupDone  <= 1'b0;
            lookupHit   <= 1'b0;
            lookupPorts <= 10'h000;
        end
        else
        begin
            lookupDone  <= lookupValid;
            lookupHit   <= lookupValid & lkHit[3];
            lookupPorts <= (lookupValid & lkHit[3])
                           ? ePorts[lkHit[2:0]] : 10'h000;
        end
    end

    // ------------------------------------------------------------
    // Table update: management, learning, aging
    // ------------------------------------------------------------
    wire mgmtBusy = cmdValid && (cmdOp == `MATL_CMD_ADD
                    || cmdOp == `MATL_CMD_DEL || cmdOp == `MATL_CMD_PROMOTE);

    always @(posedge core_clk)
    begin
        if (!resetn)
        begin
            eValid  <= 8'h00;     // Entry data is only read when valid
            eStatic <= 8'h00;
            ageTime <= `MATL_AGE_DEFAULT;
            cmdDone <= 1'b0;
            cmdOk   <= 1'b0;
            rdValid <= 1'b0;
            rdMac   <= 48'h000000000000;
            rdVlan  <= 12'h000;
            rdStatic <= 1'b0;
            rdPorts <= 10'h000;
            lastKey <= 60'h000000000000000;
            rdFirst <= 1'b1;
        end
        else
        begin
            cmdDone <= cmdValid;
            cmdOk   <= 1'b0;
            rdValid <= 1'b0;
            // Aging: seconds unseen, held against the current interval
            if (secTick)
                for (i = 0; i < 8; i = i + 1)
                    if (eValid[i[2:0]] && !eStatic[i[2:0]])
                    begin
                        if (eAge[i[2:0]] + 10'h001 >= ageTime)
                            eValid[i[2:0]] <= 1'b0;
                        else
                            eAge[i[2:0]] <= eAge[i[2:0]] + 10'h001;
                    end
            // Learning, yields to a table-writing command
            if (learnValid && !mgmtBusy)
            begin
                if (lnHit[3])
                begin
                    if (!eStatic[lnHit[2:0]])
                    begin
                        eValid[lnHit[2:0]] <= 1'b1;  // Beats aging
                        ePorts[lnHit[2:0]] <= learnPort;
                        eAge[lnHit[2:0]]   <= 10'h000;
                    end
                end
                else if (freeIdx[3])
                begin
                    eValid[freeIdx[2:0]]  <= 1'b1;
                    eStatic[freeIdx[2:0]] <= 1'b0;
                    eMac[freeIdx[2:0]]    <= learnMac;
                    eVlan[freeIdx[2:0]]   <= learnVlan;
                    ePorts[freeIdx[2:0]]  <= learnPort;
                    eAge[freeIdx[2:0]]    <= 10'h000;
                end
            end
            // Management commands
            if (cmdValid)
            begin
                case (cmdOp)
                    `MATL_CMD_ADD:
                    begin
                        if (cmHit[3] || freeIdx[3])
                        begin
                            eValid[addSlot]  <= 1'b1;
                            eStatic[addSlot] <= 1'b1;
                            eMac[addSlot]    <= cmdMac;
                            eVlan[addSlot]   <= cmdVlan;
                            ePorts[addSlot]  <= cmdPorts;
                            cmdOk <= 1'b1;
                        end
                    end
                    `MATL_CMD_DEL:
                    begin
                        if (cmHit[3] && eStatic[cmHit[2:0]])
                        begin
                            eValid[cmHit[2:0]] <= 1'b0;
                            cmdOk <= 1'b1;
                        end
                    end
                    `MATL_CMD_PROMOTE:
                    begin
                        if (cmHit[3] && !eStatic[cmHit[2:0]])
                        begin
                            eValid[cmHit[2:0]]  <= 1'b1;
                            eStatic[cmHit[2:0]] <= 1'b1;
                            cmdOk <= 1'b1;
                        end
                    end
                    `MATL_CMD_AGE:
                    begin
                        if (cmdAge >= `MATL_AGE_MIN
                            && cmdAge <= `MATL_AGE_MAX)
                        begin
                            ageTime <= cmdAge;
                            cmdOk   <= 1'b1;
                        end
                    end
                    `MATL_CMD_READ:
                    begin
                        if (!cmdMac[0] && nextRd[3])
                        begin
                            rdValid  <= 1'b1;
                            rdMac    <= eMac[nextRd[2:0]];
                            rdVlan   <= eVlan[nextRd[2:0]];
                            rdStatic <= eStatic[nextRd[2:0]];
                            rdPorts  <= ePorts[nextRd[2:0]];
                            lastKey  <= bestKey;
                            rdFirst  <= 1'b0;
                            cmdOk    <= 1'b1;
                        end
                        else
                            rdFirst <= 1'b1;
                    end
                    default:
                        cmdOk <= 1'b0;
                endcase
            end
        end
    end
endmodule // matl_table
`default_nettype wire

//--- matl_tb.sv
// Self-checking bench for the MAC address table
`timescale 1ns/10ps
`default_nettype none
`include "matl_consts.vh"
// ------------------------------
// Bench top
// ------------------------------
module tb;
    logic        core_clk = 1'h0, resetn = 1'h0, cmdValid = 1'h0;
    logic [2:0]  cmdOp = 3'h0;
    logic [47:0] cmdMac = 48'h0;
    logic [11:0] cmdVlan = 12'h0;
    logic [9:0]  cmdPorts = 10'h0, cmdAge = 10'h0;
    logic [47:0] lookupMac, learnMac, rdMac;
    logic [11:0] lookupVlan, learnVlan, rdVlan;
    logic [9:0]  learnPort, lookupPorts, rdPorts, ageTime, prt;
    logic        lookupValid, lookupDone, lookupHit, learnValid;
    logic        cmdDone, cmdOk, rdValid, rdStatic, hit, done;
    int          failures = 0, checks = 0, cyc = 0;

    matl_table #(.SEC_CYCLES(24'h00000a)) uut (
        .core_clk(core_clk), .resetn(resetn), .lookupValid(lookupValid),
        .lookupMac(lookupMac), .lookupVlan(lookupVlan),
        .lookupDone(lookupDone), .lookupHit(lookupHit),
        .lookupPorts(lookupPorts), .learnValid(learnValid),
        .learnMac(learnMac), .learnVlan(learnVlan), .learnPort(learnPort),
        .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdMac(cmdMac),
        .cmdVlan(cmdVlan), .cmdPorts(cmdPorts), .cmdAge(cmdAge),
        .cmdDone(cmdDone), .cmdOk(cmdOk), .rdValid(rdValid), .rdMac(rdMac),
        .rdVlan(rdVlan), .rdStatic(rdStatic), .rdPorts(rdPorts),
        .ageTime(ageTime));
    matl_pipe_model pm (
        .core_clk(core_clk), .lookupValid(lookupValid),
        .lookupMac(lookupMac), .lookupVlan(lookupVlan),
        .lookupDone(lookupDone), .lookupHit(lookupHit),
        .lookupPorts(lookupPorts), .learnValid(learnValid),
        .learnMac(learnMac), .learnVlan(learnVlan), .learnPort(learnPort));

    // 10 MHz clock and a hang limit
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            failures++;
            report_and_stop;
        end
    end

    task automatic chk(input string n, input logic [71:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask

    // One management command, answer checked next cycle
    task automatic cmd(input logic [2:0] op, input logic [47:0] m,
        input logic [11:0] v, input logic [9:0] p, a, input logic ok);
        @(negedge core_clk);
        {cmdOp, cmdMac, cmdVlan, cmdPorts, cmdAge} = {op, m, v, p, a};
        cmdValid = 1'h1;
        @(negedge core_clk);
        cmdValid = 1'h0;
        chk("cmdDone", cmdDone, 1'h1);
        chk("cmdOk", cmdOk, ok);
    endtask

    task automatic look(input logic [47:0] m, input logic [11:0] v,
                        input logic h, input logic [9:0] p);
        pm.lookup(m, v, hit, prt, done);
        chk("lookupDone", done, 1'h1);
        chk("lookupHit", hit, h);
        chk("lookupPorts", prt, p);
    endtask

    task t_learn;
        pm.learn(48'h0a00, 12'h001, 10'h004);
        look(48'h0a00, 12'h001, 1'h1, 10'h004);
        look(48'h0a00, 12'h002, 1'h0, 10'h000);
        pm.learn(48'h0a00, 12'h001, 10'h008);
        look(48'h0a00, 12'h001, 1'h1, 10'h008);
    endtask

    task t_static;
        cmd(`MATL_CMD_ADD, 48'h0b00, 12'h001, 10'h011, 10'h0, 1'h1);
        pm.learn(48'h0b00, 12'h001, 10'h002);
        look(48'h0b00, 12'h001, 1'h1, 10'h011);
        cmd(`MATL_CMD_PROMOTE, 48'h0b00, 12'h001, 10'h0, 10'h0, 1'h0);
        cmd(`MATL_CMD_DEL, 48'h0b00, 12'h001, 10'h0, 10'h0, 1'h1);
        look(48'h0b00, 12'h001, 1'h0, 10'h000);
        cmd(`MATL_CMD_DEL, 48'h0a00, 12'h001, 10'h0, 10'h0, 1'h0);
    endtask

    task t_age;
        logic [9:0] ages [4] = '{10'h009, 10'h277, 10'h276, 10'h00a};
        chk("ageTime", ageTime, `MATL_AGE_DEFAULT);
        for (int i = 0; i < 4; i++)
        begin
            cmd(`MATL_CMD_AGE, 48'h0, 12'h0, 10'h0, ages[i], i > 1);
            chk("ageTime", ageTime,
                i > 1 ? ages[i] : `MATL_AGE_DEFAULT);
        end
        pm.learn(48'h0c00, 12'h001, 10'h040);
        pm.learn(48'h0d00, 12'h001, 10'h020);
        cmd(`MATL_CMD_PROMOTE, 48'h0c00, 12'h001, 10'h0, 10'h0, 1'h1);
        look(48'h0d00, 12'h001, 1'h1, 10'h020);
        repeat (150) @(negedge core_clk);
        look(48'h0d00, 12'h001, 1'h0, 10'h000);
        look(48'h0a00, 12'h001, 1'h0, 10'h000);
        look(48'h0c00, 12'h001, 1'h1, 10'h040);
    endtask

    task t_read;
        logic [71:0] ent [3] = '{{1'h1, 12'h001, 48'h0a00, 1'h0, 10'h008},
            {1'h1, 12'h001, 48'h0c00, 1'h1, 10'h040},
            {1'h1, 12'h002, 48'h0100, 1'h1, 10'h001}};
        pm.learn(48'h0a00, 12'h001, 10'h008);
        cmd(`MATL_CMD_ADD, 48'h0100, 12'h002, 10'h001, 10'h0, 1'h1);
        cmd(`MATL_CMD_READ, 48'h1, 12'h0, 10'h0, 10'h0, 1'h0);
        chk("rdValid", rdValid, 1'h0);
        for (int i = 0; i < 4; i++)
        begin
            cmd(`MATL_CMD_READ, 48'h0, 12'h0, 10'h0, 10'h0, i < 3);
            if (i < 3)
                chk("entry", {rdValid, rdVlan, rdMac, rdStatic, rdPorts},
                    ent[i]);
            else
                chk("rdValid", rdValid, 1'h0);
        end
    endtask

    task report_and_stop;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Reset for five cycles, then each scenario in turn
    initial
    begin
        repeat (5) @(negedge core_clk);
        resetn = 1'h1;
        t_learn;
        t_static;
        t_age;
        t_read;
        report_and_stop;
    end
endmodule // tb
`default_nettype wire
